/* logic/lmpc_pkg.sv */
// Constants, types and lookup tables shared by the LED mode and pattern controller.
// Operation
// - Override bit for group A forces its current limit to the lowest level.
// - Override bit for group B forces its current limit to the lowest level.
// - Reset loads defaults: scan plus audio mode, both RGB groups disabled.
// - Shutdown setting in configuration turns every output sink off.
// - Shutdown keeps all register contents unchanged.
// - Mode field 01 selects audio-only mode; outputs follow audio amplitude.
// - Scan current level comes from gain register bits 4 to 2.
// - Constant-current bit keeps scanned outputs on without stepping.
// - Enabled RGB groups drive channels 0-2 and 7-9; channels 3-6 scan.
// - Rate zero scans eight 22 ms intervals, starting all off.
// - Configuration bits 3 to 1 select the scan interval rate.
// - A disabled RGB group follows the scan sequence.
// - With both groups enabled the group current comes from the current register.
// - Host intensity mode: duty changes only when software writes new bytes.
// - Host mode duty scales linearly over 256 steps, 00 off, FF full.
// - One-shot mode bits make each channel follow its own timing codes.
// - New timing codes take effect only after a write to update register.
// - Hold-off runs once, after update write or entry into one-shot mode.
// - Ramp-up walks 32 equal steps up the gamma table.
// - Hold full duty, then ramp down 32 equal steps to zero.
// - Off time follows ramp-down, then the waveform restarts at ramp-up.
// - Ramp steps map to the 32-entry gamma table.
// - Long codes: 0 is zero, 1 is 0.13 s, each next code doubles, up to 66.56 s at code 10.
// - Ramp codes: 0 is 0.13 s, each increment doubles, up to 16.64 s.
// - Host duty bytes sit in registers 04h to 09h, one per channel.
package lmpc_pkg;
   // ****************************************************************
   // Register indices; the byte address is four times the index.
   // ****************************************************************
   localparam logic [5:0] REG_CFG = 6'h00;
   localparam logic [5:0] REG_GAIN = 6'h01;
   localparam logic [5:0] REG_RGBM = 6'h02;
   localparam logic [5:0] REG_RGBCUR = 6'h03;
   localparam logic [5:0] REG_PWM0 = 6'h04;
   localparam logic [5:0] REG_HOLDOFF_0 = 6'h0A;
   localparam logic [5:0] REG_T12_0 = 6'h10;
   localparam logic [5:0] REG_T34_0 = 6'h16;
   localparam logic [5:0] REG_UPD = 6'h1C;
   localparam logic [5:0] REG_EN_LO = 6'h1D;
   localparam logic [5:0] REG_EN_HI = 6'h1E;
   localparam logic [5:0] REG_TOPDN = 6'h1F;
   localparam logic [5:0] REG_GROUP_LOW_CURRENT_OVERRIDE = 6'h20;
   localparam logic [5:0] REG_STAT = 6'h21;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] EN_LO_RST = 8'hFF;
   localparam logic [7:0] EN_HI_RST = 8'hC0;
   localparam int CFG_SD_BIT = 0;
   localparam int CFG_GA_EN_BIT = 4;
   localparam int CFG_GB_EN_BIT = 5;
   localparam int TOPDN_CC_BIT = 4;
   localparam int RGBM_A_BIT = 5;
   localparam int RGBM_B_BIT = 4;
   localparam int G2_A_BIT = 1;
   localparam int G2_B_BIT = 0;
   localparam logic [1:0] MODE_AUDIO = 2'h1;
   localparam logic [1:0] MODE_SCAN = 2'h2;
   localparam logic [2:0] CUR_LOW_LEVEL = 3'h4;
   // ****************************************************************
   // Time base.
   // ****************************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int BASE_TICK_US = 1000;
   localparam int BASE_CYC = CLK_HZ / 1_000_000 * BASE_TICK_US;
   localparam int TIME_UNIT_MS = 130;
   localparam int SCAN_INTERVAL_MS = 22;
   localparam logic [16:0] UNIT_TICKS = 17'(TIME_UNIT_MS * 1000 / BASE_TICK_US);
   localparam logic [7:0] SCAN_TICKS = 8'(SCAN_INTERVAL_MS * 1000 / BASE_TICK_US);
   localparam logic [4:0] LAST_STEP = 5'h1F;
   localparam logic [3:0] LONG_CODE_MAX = 4'hA;
   typedef enum logic [4:0] {
      PH_HOLDOFF = 5'h01,
      PH_RAMPUP = 5'h02,
      PH_HOLDON = 5'h04,
      PH_RAMPDN = 5'h08,
      PH_OFF = 5'h10
   } lmpc_phase_t;
   localparam logic [7:0] GAMMA [32] = '{
      8'h00, 8'h01, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h10, 8'h15, 8'h1A, 8'h20, 8'h26, 8'h2D, 8'h34, 8'h3C, 8'h44, 8'h4C,
      8'h55, 8'h5F, 8'h69, 8'h73, 8'h7D, 8'h88, 8'h94, 8'hA0, 8'hAC, 8'hB9, 8'hC6, 8'hD3, 8'hE1, 8'hEF, 8'hFE, 8'hFF};
   localparam logic [3:0] SCAN_PAT [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h7, 4'h3, 4'h1};
   // Hold-off, hold-on and off durations in base ticks; codes above the table clamp.
   function automatic logic [16:0] long_ticks(input logic [3:0] code);
      logic [3:0] c;
      c = (code > LONG_CODE_MAX) ? LONG_CODE_MAX : code;
      long_ticks = (c == 4'h0) ? 17'h0 : 17'(UNIT_TICKS << (c - 4'h1));
   endfunction : long_ticks
   // Duration of one of the 32 ramp steps in base ticks.
   function automatic logic [16:0] step_ticks(input logic [2:0] code);
      step_ticks = 17'((UNIT_TICKS << code) >> 5);
   endfunction : step_ticks
endpackage : lmpc_pkg

/* logic/lmpc_core.sv */
// LED mode, scan and one-shot pattern controller with its Avalon-MM register file.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module lmpc_core import lmpc_pkg::*; #(
   parameter int BASE_CYC_P = BASE_CYC
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic srst,
   // Avalon-MM slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // LED sink controls.
   output logic [9:0] sink_on_ff,
   output logic [2:0] group_a_level_ff,
   output logic [2:0] group_b_level_ff,
   output logic [2:0] scan_level_ff,
   output logic [2:0] audio_gain_ff,
   output logic audio_follow_ff
);
   localparam int TBW = (BASE_CYC_P > 1) ? $clog2(BASE_CYC_P) : 1;
   if (BASE_CYC_P < 2) begin : g_bad_base
      $error("BASE_CYC_P must be at least 2");
   end

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] gain;
      logic [7:0] rgbm;
      logic [7:0] rgbcur;
      logic [5:0][7:0] pwm;
      logic [5:0][7:0] t0w;
      logic [5:0][7:0] t12w;
      logic [5:0][7:0] t34w;
      logic [5:0][7:0] t0a;
      logic [5:0][7:0] t12a;
      logic [5:0][7:0] t34a;
      logic [9:0] en;
      logic topdn;
      logic [1:0] gain2;
      logic wait_n;
      logic [31:0] rdata;
      logic [TBW-1:0] tb_cnt;
      logic tick;
      logic [10:0] scan_cnt;
      logic [2:0] scan_idx;
      logic [7:0] pwm_cnt;
      logic [5:0][4:0] ph;
      logic [5:0][4:0] stp;
      logic [5:0][16:0] tcnt;
      logic [9:0] sink;
      logic [2:0] lvl_a;
      logic [2:0] lvl_b;
      logic [2:0] lvl_scan;
      logic [2:0] again;
      logic follow;
   } lmpc_state_t;

   lmpc_state_t st_ff;
   lmpc_state_t nxt_st;

   logic acc;
   logic wr;
   logic upd_wr;
   logic [1:0] mode;
   logic sd;

   assign acc = (avs_read || avs_write) && !st_ff.wait_n;
   assign wr = avs_write && st_ff.wait_n;
   assign upd_wr = wr && (avs_address == REG_UPD);
   assign mode = st_ff.cfg[7:6];
   assign sd = st_ff.cfg[CFG_SD_BIT];

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   always_comb begin
      logic [5:0] oneshot;
      logic [5:0] grp_en;
      logic [5:0] enter;
      logic [3:0] pat;
      logic [7:0] duty;
      logic [2:0] tcode;
      logic [31:0] rd;
      int k;
      int s;
      nxt_st = st_ff;
      oneshot = '0;
      grp_en = '0;
      enter = '0;
      pat = '0;
      duty = '0;
      tcode = '0;
      rd = '0;
      k = 0;
      s = 0;
      // Bus handshake: one cycle of wait, then a single-cycle answer.
      nxt_st.wait_n = acc;
      if (acc) begin
         unique case (avs_address)
            REG_CFG: rd = {24'h0, st_ff.cfg};
            REG_GAIN: rd = {24'h0, st_ff.gain};
            REG_RGBM: rd = {24'h0, st_ff.rgbm};
            REG_RGBCUR: rd = {24'h0, st_ff.rgbcur};
            REG_EN_LO: rd = {24'h0, st_ff.en[7:0]};
            REG_EN_HI: rd = {24'h0, st_ff.en[9:8], 6'h0};
            REG_TOPDN: rd = {27'h0, st_ff.topdn, 4'h0};
            REG_GROUP_LOW_CURRENT_OVERRIDE: rd = {30'h0, st_ff.gain2};
            REG_STAT: rd = {21'h0, st_ff.scan_idx, st_ff.sink[9:2]};
            default: begin
               for (k = 0; k < 6; k++) begin
                  if (avs_address == REG_PWM0 + 6'(k)) rd = {24'h0, st_ff.pwm[k]};
                  if (avs_address == REG_HOLDOFF_0 + 6'(k)) rd = {24'h0, st_ff.t0w[k]};
                  if (avs_address == REG_T12_0 + 6'(k)) rd = {24'h0, st_ff.t12w[k]};
                  if (avs_address == REG_T34_0 + 6'(k)) rd = {24'h0, st_ff.t34w[k]};
               end
            end
         endcase
      end
      nxt_st.rdata = rd;
      if (wr) begin
         unique case (avs_address)
            REG_CFG: nxt_st.cfg = avs_writedata[7:0];
            REG_GAIN: nxt_st.gain = avs_writedata[7:0];
            REG_RGBM: nxt_st.rgbm = avs_writedata[7:0];
            REG_RGBCUR: nxt_st.rgbcur = avs_writedata[7:0];
            REG_EN_LO: nxt_st.en[7:0] = avs_writedata[7:0];
            REG_EN_HI: nxt_st.en[9:8] = avs_writedata[7:6];
            REG_TOPDN: nxt_st.topdn = avs_writedata[TOPDN_CC_BIT];
            REG_GROUP_LOW_CURRENT_OVERRIDE: nxt_st.gain2 = avs_writedata[1:0];
            default: begin
               for (k = 0; k < 6; k++) begin
                  if (avs_address == REG_PWM0 + 6'(k)) nxt_st.pwm[k] = avs_writedata[7:0];
                  if (avs_address == REG_HOLDOFF_0 + 6'(k)) nxt_st.t0w[k] = avs_writedata[7:0];
                  if (avs_address == REG_T12_0 + 6'(k)) nxt_st.t12w[k] = avs_writedata[7:0];
                  if (avs_address == REG_T34_0 + 6'(k)) nxt_st.t34w[k] = avs_writedata[7:0];
               end
            end
         endcase
      end
      // Timing codes move to the working copies only on an update write.
      if (upd_wr) begin
         nxt_st.t0a = st_ff.t0w;
         nxt_st.t12a = st_ff.t12w;
         nxt_st.t34a = st_ff.t34w;
      end
      // Shared base tick for scan and pattern timing.
      nxt_st.tick = 1'b0;
      nxt_st.tb_cnt = st_ff.tb_cnt + TBW'(1);
      if (st_ff.tb_cnt == TBW'(BASE_CYC_P - 1)) begin
         nxt_st.tb_cnt = '0;
         nxt_st.tick = 1'b1;
      end
      nxt_st.pwm_cnt = st_ff.pwm_cnt + 8'h01;
      // Scan interval sequencer; rate code stretches each interval.
      if (st_ff.tick) begin
         nxt_st.scan_cnt = st_ff.scan_cnt + 11'h001;
         if (st_ff.scan_cnt + 11'h001 >= 11'(SCAN_TICKS) * {7'h00, {1'b0, st_ff.cfg[3:1]} + 4'h1}) begin
            nxt_st.scan_cnt = '0;
            nxt_st.scan_idx = st_ff.scan_idx + 3'h1;
         end
      end
      pat = st_ff.topdn ? 4'hF : SCAN_PAT[st_ff.scan_idx];
      if (mode == MODE_AUDIO) pat = 4'hF;
      // Per RGB channel: 0-2 are group A, 3-5 are group B.
      for (k = 0; k < 6; k++) begin
         oneshot[k] = (k < 3) ? st_ff.rgbm[RGBM_A_BIT] : st_ff.rgbm[RGBM_B_BIT];
         grp_en[k] = (k < 3) ? st_ff.cfg[CFG_GA_EN_BIT] : st_ff.cfg[CFG_GB_EN_BIT];
         enter[k] = wr && (avs_address == REG_RGBM) && !oneshot[k] &&
            avs_writedata[(k < 3) ? RGBM_A_BIT : RGBM_B_BIT];
      end
      for (k = 0; k < 6; k++) begin
         if (upd_wr || enter[k]) begin
            nxt_st.ph[k] = PH_HOLDOFF;
            nxt_st.tcnt[k] = '0;
            nxt_st.stp[k] = '0;
         end else if (st_ff.tick) begin
            nxt_st.tcnt[k] = st_ff.tcnt[k] + 17'h1;
            unique case (st_ff.ph[k])
               PH_HOLDOFF: begin
                  if (st_ff.tcnt[k] + 17'h1 >= long_ticks(st_ff.t0a[k][7:4])) begin
                     nxt_st.ph[k] = PH_RAMPUP;
                     nxt_st.tcnt[k] = '0;
                     nxt_st.stp[k] = '0;
                  end
               end
               PH_RAMPUP: begin
                  tcode = st_ff.t12a[k][7:5];
                  if (st_ff.tcnt[k] + 17'h1 >= step_ticks(tcode)) begin
                     nxt_st.tcnt[k] = '0;
                     if (st_ff.stp[k] == LAST_STEP) nxt_st.ph[k] = PH_HOLDON;
                     else nxt_st.stp[k] = st_ff.stp[k] + 5'h01;
                  end
               end
               PH_HOLDON: begin
                  if (st_ff.tcnt[k] + 17'h1 >= long_ticks(st_ff.t12a[k][4:1])) begin
                     nxt_st.ph[k] = PH_RAMPDN;
                     nxt_st.tcnt[k] = '0;
                     nxt_st.stp[k] = LAST_STEP;
                  end
               end
               PH_RAMPDN: begin
                  tcode = st_ff.t34a[k][7:5];
                  if (st_ff.tcnt[k] + 17'h1 >= step_ticks(tcode)) begin
                     nxt_st.tcnt[k] = '0;
                     if (st_ff.stp[k] == 5'h00) nxt_st.ph[k] = PH_OFF;
                     else nxt_st.stp[k] = st_ff.stp[k] - 5'h01;
                  end
               end
               PH_OFF: begin
                  if (st_ff.tcnt[k] + 17'h1 >= long_ticks(st_ff.t34a[k][4:1])) begin
                     nxt_st.ph[k] = PH_RAMPUP;
                     nxt_st.tcnt[k] = '0;
                     nxt_st.stp[k] = '0;
                  end
               end
               default: nxt_st.ph[k] = PH_HOLDOFF;
            endcase
         end
      end
      // Output sinks.
      for (s = 0; s < 10; s++) begin
         if (s >= 3 && s <= 6) begin
            nxt_st.sink[s] = pat[s - 3];
         end else begin
            k = (s < 3) ? s : s - 4;
            if (!grp_en[k]) begin
               nxt_st.sink[s] = pat[k % 3];
            end else begin
               if (!oneshot[k]) duty = st_ff.pwm[k];
               else if (st_ff.ph[k] == PH_HOLDON) duty = 8'hFF;
               else if (st_ff.ph[k] == PH_RAMPUP || st_ff.ph[k] == PH_RAMPDN) duty = GAMMA[st_ff.stp[k]];
               else duty = 8'h00;
               nxt_st.sink[s] = duty > st_ff.pwm_cnt;
            end
         end
         if (sd || !st_ff.en[s]) nxt_st.sink[s] = 1'b0;
      end
      // Current levels and audio steering.
      nxt_st.lvl_a = st_ff.gain2[G2_A_BIT] ? CUR_LOW_LEVEL : {1'b0, st_ff.rgbcur[3:2]};
      nxt_st.lvl_b = st_ff.gain2[G2_B_BIT] ? CUR_LOW_LEVEL : {1'b0, st_ff.rgbcur[1:0]};
      nxt_st.lvl_scan = st_ff.gain[4:2];
      nxt_st.again = st_ff.gain[7:5];
      nxt_st.follow = !sd && (mode != MODE_SCAN);
      if (srst) begin
         nxt_st = '0;
         nxt_st.cfg = CFG_RST;
         nxt_st.en = {EN_HI_RST[7:6], EN_LO_RST};
         for (k = 0; k < 6; k++) nxt_st.ph[k] = PH_HOLDOFF;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_ff <= nxt_st;
   end

   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = !st_ff.wait_n;
   assign sink_on_ff = st_ff.sink;
   assign group_a_level_ff = st_ff.lvl_a;
   assign group_b_level_ff = st_ff.lvl_b;
   assign scan_level_ff = st_ff.lvl_scan;
   assign audio_gain_ff = st_ff.again;
   assign audio_follow_ff = st_ff.follow;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   property p_rst_default;
      @(posedge ref_clk) srst |=> (st_ff.cfg == CFG_RST) && (st_ff.rgbm == 8'h00) ##1 (sink_on_ff[2:0] == 3'h0 || !srst);
   endproperty
   a_rst_default: assert property (p_rst_default) else $error("reset defaults wrong");
   property p_grp_a_low;
      @(posedge ref_clk) disable iff (srst) st_ff.gain2[G2_A_BIT] |=> group_a_level_ff == CUR_LOW_LEVEL;
   endproperty
   a_grp_a_low: assert property (p_grp_a_low) else $error("group A override ignored");
   property p_grp_b_sel;
      @(posedge ref_clk) disable iff (srst) !st_ff.gain2[G2_B_BIT] |=> group_b_level_ff == {1'b0, $past(st_ff.rgbcur[1:0])};
   endproperty
   a_grp_b_sel: assert property (p_grp_b_sel) else $error("group B level not from current register");
   property p_sd_off;
      @(posedge ref_clk) disable iff (srst) sd |=> sink_on_ff == 10'h000;
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("sink on during shutdown");
   property p_sd_keep;
      @(posedge ref_clk) disable iff (srst) sd && !wr |=> $stable(st_ff.pwm) && $stable(st_ff.t0a);
   endproperty
   a_sd_keep: assert property (p_sd_keep) else $error("register changed in shutdown");
   property p_audio;
      @(posedge ref_clk) disable iff (srst) (mode == MODE_AUDIO) && !sd |=> audio_follow_ff;
   endproperty
   a_audio: assert property (p_audio) else $error("audio follow missing");
   property p_scan_lvl;
      @(posedge ref_clk) disable iff (srst) 1'b1 |=> scan_level_ff == $past(st_ff.gain[4:2]);
   endproperty
   a_scan_lvl: assert property (p_scan_lvl) else $error("scan level wrong");
   property p_cc;
      @(posedge ref_clk) disable iff (srst) st_ff.topdn && !sd |=> sink_on_ff[6:3] == $past(st_ff.en[6:3]);
   endproperty
   a_cc: assert property (p_cc) else $error("constant current not steady");
   property p_scan0;
      @(posedge ref_clk) disable iff (srst) st_ff.scan_idx == 3'h0 && !st_ff.topdn && mode != MODE_AUDIO
         |=> sink_on_ff[6:3] == 4'h0;
   endproperty
   a_scan0: assert property (p_scan0) else $error("interval zero not dark");
   property p_upd;
      @(posedge ref_clk) disable iff (srst) !upd_wr |=> $stable(st_ff.t12a) && $stable(st_ff.t34a);
   endproperty
   a_upd: assert property (p_upd) else $error("timing changed without update");
   property p_host_zero;
      @(posedge ref_clk) disable iff (srst) st_ff.cfg[CFG_GA_EN_BIT] && !st_ff.rgbm[RGBM_A_BIT] && st_ff.pwm[0] == 8'h00
         |=> !sink_on_ff[0];
   endproperty
   a_host_zero: assert property (p_host_zero) else $error("zero duty lit");
   property p_host_full;
      @(posedge ref_clk) disable iff (srst) st_ff.cfg[CFG_GA_EN_BIT] && !st_ff.rgbm[RGBM_A_BIT] && !sd
         && st_ff.en[2] && st_ff.pwm[2] == 8'hFF && st_ff.pwm_cnt != 8'hFF |=> sink_on_ff[2];
   endproperty
   a_host_full: assert property (p_host_full) else $error("full duty dark");
   property p_hold_full;
      @(posedge ref_clk) disable iff (srst) st_ff.cfg[CFG_GA_EN_BIT] && st_ff.rgbm[RGBM_A_BIT] && !sd
         && st_ff.en[0] && st_ff.ph[0] == PH_HOLDON && st_ff.pwm_cnt != 8'hFF |=> sink_on_ff[0];
   endproperty
   a_hold_full: assert property (p_hold_full) else $error("hold phase not at full duty");
   property p_upd_load;
      @(posedge ref_clk) disable iff (srst) upd_wr
         |=> st_ff.t12a == $past(st_ff.t12w) && st_ff.t34a == $past(st_ff.t34w);
   endproperty
   a_upd_load: assert property (p_upd_load) else $error("update did not load timing");
   property p_holdoff_start;
      @(posedge ref_clk) disable iff (srst) upd_wr |=> st_ff.ph[0] == PH_HOLDOFF && st_ff.tcnt[0] == 17'h0;
   endproperty
   a_holdoff_start: assert property (p_holdoff_start) else $error("update did not restart hold-off");
   property p_group_follow;
      @(posedge ref_clk) disable iff (srst) !st_ff.cfg[CFG_GB_EN_BIT] && st_ff.en[9] && st_ff.en[5]
         |=> sink_on_ff[9] == sink_on_ff[5];
   endproperty
   a_group_follow: assert property (p_group_follow) else $error("disabled group not scanning");
   c_oneshot_hold: cover property (@(posedge ref_clk) disable iff (srst) st_ff.ph[0] == PH_HOLDON);
   c_scan_full: cover property (@(posedge ref_clk) disable iff (srst) st_ff.scan_idx == 3'h4);
   c_shutdown: cover property (@(posedge ref_clk) disable iff (srst) sd ##1 !sd);
   c_ramp_end: cover property (@(posedge ref_clk) disable iff (srst) st_ff.ph[0] == PH_RAMPDN ##1 st_ff.ph[0] == PH_OFF);
endmodule : lmpc_core

/* testbench/lmpc_led_model.sv */
// Model of the LED strings that counts the on cycles of each sink.
`timescale 1ns/1ps
module lmpc_led_model (
   // Clock.
   input wire logic ref_clk,
   // Sink drive and measurement gate.
   input wire logic [9:0] sink_on_ff,
   input wire logic gate,
   // On-cycle counts.
   output logic [15:0] on_cnt [10]
);
   // String current averages to the on cycles seen while the gate is open.
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 10; i++) begin
         on_cnt[i] <= gate ? on_cnt[i] + 16'(sink_on_ff[i]) : 16'h0000;
      end
   end
endmodule : lmpc_led_model

/* testbench/test_lmpc_core.sv */
// Self-checking testbench of the LED mode and pattern controller.
`timescale 1ns/1ps
module test_lmpc_core import lmpc_pkg::*;;
   localparam int BC = 4;
   localparam int IV = 22 * BC;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic gate = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [9:0] sink_on_ff;
   logic [2:0] group_a_level_ff, group_b_level_ff, scan_level_ff, audio_gain_ff;
   logic audio_follow_ff;
   logic [15:0] on_cnt [10];
   logic [7:0] q;
   logic [3:0] pat [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h7, 4'h3, 4'h1};
   logic [7:0] duty [6] = '{8'h00, 8'h40, 8'hFF, 8'h01, 8'h80, 8'hC3};
   int chn [6] = '{0, 1, 2, 7, 8, 9};
   int fails = 0;
   int comparisons = 0;
   int wn;
   int iv;
   always #20 ref_clk = ~ref_clk;
   lmpc_core #(.BASE_CYC_P(BC)) DUT (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sink_on_ff(sink_on_ff), .group_a_level_ff(group_a_level_ff),
      .group_b_level_ff(group_b_level_ff), .scan_level_ff(scan_level_ff), .audio_gain_ff(audio_gain_ff),
      .audio_follow_ff(audio_follow_ff));
   lmpc_led_model strings (.ref_clk(ref_clk), .sink_on_ff(sink_on_ff), .gate(gate), .on_cnt(on_cnt));
   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task test_done;
      $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   // One Avalon access, held until waitrequest is sampled low.
   task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h000000, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 40) begin
         fails++;
         test_done();
      end
   endtask : acc
   task wr(input logic [5:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      repeat (3) @(posedge ref_clk);
   endtask : wr
   task rd(input string nm, input logic [5:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(nm, {24'h000000, e}, {24'h000000, q});
   endtask : rd
   task meas(input int n);
      @(posedge ref_clk);
      gate <= 1'b1;
      repeat (n) @(posedge ref_clk);
      gate <= 1'b0;
      @(negedge ref_clk);
   endtask : meas
   task wait_bit(input int ch, input logic v);
      wn = 0;
      while (sink_on_ff[ch] !== v && wn < 4000) begin
         @(posedge ref_clk);
         wn++;
      end
      if (wn == 4000) begin
         fails++;
         test_done();
      end
   endtask : wait_bit
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      rd("cfg", REG_CFG, 8'h00);
      rd("en_lo", REG_EN_LO, 8'hFF);
      rd("en_hi", REG_EN_HI, 8'hC0);
      rd("override", REG_GROUP_LOW_CURRENT_OVERRIDE, 8'h00);
      chk("follow", 1'b1, audio_follow_ff);
      wr(6'h3F, 8'hFF);
      rd("unmapped", 6'h3F, 8'h00);
      $display("Test reset done");
      wr(REG_RGBCUR, 8'h06);
      chk("level a", 3'h1, group_a_level_ff);
      chk("level b", 3'h2, group_b_level_ff);
      wr(REG_GROUP_LOW_CURRENT_OVERRIDE, 8'h02);
      chk("level a", 3'h4, group_a_level_ff);
      chk("level b", 3'h2, group_b_level_ff);
      wr(REG_GROUP_LOW_CURRENT_OVERRIDE, 8'h01);
      chk("level a", 3'h1, group_a_level_ff);
      chk("level b", 3'h4, group_b_level_ff);
      wr(REG_GAIN, 8'hAC);
      chk("scan level", 3'h3, scan_level_ff);
      chk("audio gain", 3'h5, audio_gain_ff);
      wr(REG_CFG, 8'h40);
      chk("follow", 1'b1, audio_follow_ff);
      wr(REG_CFG, 8'h80);
      chk("follow", 1'b0, audio_follow_ff);
      $display("Test levels and modes done");
      for (int r = 0; r < 3; r += 2) begin
         iv = IV * (r + 1);
         wr(REG_CFG, 8'(8'h80 | (r << 1)));
         wait_bit(3, 1'b0);
         wait_bit(3, 1'b1);
         repeat (iv / 2) @(posedge ref_clk);
         for (int k = 1; k < 8; k++) begin
            chk("scan", pat[k], sink_on_ff[6:3]);
            chk("group a scan", sink_on_ff[5:3], sink_on_ff[2:0]);
            chk("group b scan", sink_on_ff[5:3], sink_on_ff[9:7]);
            repeat (iv) @(posedge ref_clk);
         end
         chk("scan idle", 4'h0, sink_on_ff[6:3]);
         wait_bit(3, 1'b1);
         chk("scan period", iv - iv / 2, wn);
      end
      $display("Test scan done");
      wr(REG_TOPDN, 8'h10);
      meas(256);
      chk("constant", 256, on_cnt[6]);
      chk("constant", 256, on_cnt[0]);
      wr(REG_CFG, 8'h85);
      meas(256);
      chk("shutdown", 0, on_cnt[6]);
      chk("shutdown", 0, on_cnt[0]);
      rd("cfg", REG_CFG, 8'h85);
      rd("gain", REG_GAIN, 8'hAC);
      rd("current", REG_RGBCUR, 8'h06);
      wr(REG_CFG, 8'h84);
      meas(256);
      chk("restored", 256, on_cnt[5]);
      wr(REG_TOPDN, 8'h00);
      $display("Test constant and shutdown done");
      wr(REG_CFG, 8'hB0);
      for (int i = 0; i < 6; i++) begin
         wr(REG_PWM0 + 6'(i), duty[i]);
      end
      for (int j = 0; j < 2; j++) begin
         meas(256);
         for (int i = 0; i < 6; i++) begin
            chk("host duty", duty[i], on_cnt[chn[i]]);
         end
      end
      $display("Test host intensity done");
      wr(REG_HOLDOFF_0, 8'h10);
      wr(REG_T12_0, 8'h02);
      wr(REG_T34_0, 8'h02);
      wr(REG_RGBM, 8'h20);
      repeat (560) @(posedge ref_clk);
      meas(256);
      chk("old timing", 1'b1, on_cnt[0] > 16'd100);
      wr(REG_UPD, 8'h5A);
      meas(480);
      chk("hold-off", 0, on_cnt[0]);
      repeat (620) @(posedge ref_clk);
      meas(256);
      chk("hold-on", 255, on_cnt[0]);
      repeat (750) @(posedge ref_clk);
      meas(256);
      chk("off", 0, on_cnt[0]);
      repeat (800) @(posedge ref_clk);
      meas(256);
      chk("second hold-on", 255, on_cnt[0]);
      chk("group b host", 128, on_cnt[8]);
      rd("update", REG_UPD, 8'h00);
      $display("Test one-shot done");
      test_done();
   end
endmodule : test_lmpc_core
